// ### lics_pkg.sv
package lics_pkg;

  // Charge cycle states.
  typedef enum logic [3:0] {
    LICS_SHUTDOWN = 4'h0,
    LICS_STANDBY = 4'h1,
    LICS_PRECOND = 4'h2,
    LICS_CONST_CUR = 4'h3,
    LICS_CONST_VOLT = 4'h4,
    LICS_COMPLETE = 4'h5,
    LICS_TIMER_FAULT = 4'h6,
    LICS_TEMP_FAULT = 4'h7,
    LICS_BREAK = 4'h8
  } lics_state_t;

  // Safety timer period options.
  typedef enum logic [1:0] {
    LICS_TMR_OFF = 2'h0,
    LICS_TMR_4H = 2'h1,
    LICS_TMR_6H = 2'h2,
    LICS_TMR_8H = 2'h3
  } lics_tmr_opt_t;

  // Regulation voltage options.
  typedef enum logic [1:0] {
    LICS_VREG_420 = 2'h0,
    LICS_VREG_435 = 2'h1,
    LICS_VREG_440 = 2'h2,
    LICS_VREG_450 = 2'h3
  } lics_vreg_t;

  // Current setting chosen for the pass path.
  typedef enum logic [1:0] {
    LICS_ISET_AC = 2'h0,
    LICS_ISET_USB_1UL = 2'h1,
    LICS_ISET_USB_5UL = 2'h2,
    LICS_ISET_NONE = 2'h3
  } lics_iset_t;

  // Comparator results from the analog front end, all active high.
  typedef struct packed {
    logic ac_uvlo_ok;
    logic usb_uvlo_ok;
    logic supply_above_bat;
    logic battery_present;
    logic bat_below_precond;
    logic bat_at_vreg;
    logic bat_below_recharge;
    logic term_current_low;
    logic battery_temp_sense_pin_in_window;
    logic die_overtemp;
  } lics_cmp_t;

  // Decoded current-set pins.
  typedef struct packed {
    logic ac_set_high_z;
    logic ac_set_floating;
    logic usb_rate_high;
    logic usb_rate_floating;
  } lics_pins_t;

  localparam int LICS_CMP_W = 10;
  localparam int LICS_PIN_W = 4;
  localparam int LICS_CLK_HZ = 40000000;
  localparam int LICS_TERM_FILTER_MS = 1;
  localparam int LICS_TERM_FILTER_CYC = LICS_CLK_HZ / 1000 * LICS_TERM_FILTER_MS;
  localparam int LICS_TICK_CYC = LICS_CLK_HZ;
  localparam int LICS_TMR_4H_S = 14400;
  localparam int LICS_TMR_6H_S = 21600;
  localparam int LICS_TMR_8H_S = 28800;
  localparam int LICS_TMR_W = 15;
  localparam int LICS_BREAK_CYC = 4;
  localparam lics_state_t LICS_STATE_RST = LICS_SHUTDOWN;

endpackage

// ### lics_sync.sv
`timescale 1ns/10ps
module lics_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Data.
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      meta <= '0;
      q <= '0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// ### lics_divider.sv
`timescale 1ns/10ps
module lics_divider #(
  parameter int DIV = 40000000
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Run enable and tick.
  input wire logic run,
  output logic tick
);

  localparam int CW = $clog2(DIV + 1);

  logic [CW-1:0] count;
  wire logic at_end = (count == CW'(DIV - 1));

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count <= '0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= run && at_end;
      if (!run)
        count <= count;
      else if (at_end)
        count <= '0;
      else
        count <= count + CW'(1);
    end
  end

endmodule

// ### lics_sequencer.sv
// Function
// R1: Shutdown while the selected supply is below its lockout threshold.
// R2: With battery present, stay off until supply exceeds battery by 100 mV.
// R3: Lockout is checked every cycle and forces shutdown at once.
// R4: USB is used when AC is absent; AC wins when both valid.
// R5: A source change opens the old path before closing the new one.
// R6: A source change neither resets nor pauses the safety timer.
// R7: A cycle starts only with lockout passed and battery or load present.
// R8: AC set pin above 70 kilo-ohms shuts down; floating gives standby.
// R9: USB rate select low is one unit load, high five; floating gives standby.
// R10: Safety timer runs while the enable input is low, stops while high.
// R11: Timer period is a build option: off, four, six or eight hours.
// R12: Battery below precondition threshold enters preconditioning at reduced current.
// R13: Battery above precondition threshold moves on to constant current.
// R14: Entering constant current resets the timer; stay until regulation voltage.
// R15: Timer expiry flags a fault held until battery, pin or power removed. Here only constant current flags it; expiry in precondition is ignored.
// R16: After a fault, battery or pin removal gives standby until restored.
// R17: Power loss shuts down; return of power restarts the normal sequence.
// R18: At regulation voltage enter constant voltage; target is a build option.
// R19: In constant voltage, low current or timer expiry latches off, complete.
// R20: The termination comparator is filtered for 1 ms before it acts.
// R21: In charge complete, battery below recharge threshold starts a new cycle.
// R22: Suspend while die exceeds 150 C; resume after about 10 C cooling.
// R23: Thermistor out of window opens the pass path and freezes the timer.
// R24: Status and power-good outputs are low or released by a fixed table.
// R25: Inputs are synchronised; reset gives shutdown with the timer cleared.
// R26: The timer advances on a prescaled tick only while enabled and charging.
`timescale 1ns/10ps
module lics_sequencer #(
  parameter lics_pkg::lics_tmr_opt_t TIMER_OPT = lics_pkg::LICS_TMR_6H,
  parameter lics_pkg::lics_vreg_t VREG_OPT = lics_pkg::LICS_VREG_420,
  parameter int TICK_CYC = lics_pkg::LICS_TICK_CYC,
  parameter int FILTER_CYC = lics_pkg::LICS_TERM_FILTER_CYC
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Analog comparator results and pin decodes.
  input wire lics_pkg::lics_cmp_t cmp_in,
  input wire lics_pkg::lics_pins_t pins_in,
  input wire logic safety_timer_enable_n,
  // Power path control.
  output logic ac_path_on,
  output logic usb_path_on,
  output lics_pkg::lics_iset_t current_setting,
  output logic precond_current,
  output logic cv_regulate,
  output lics_pkg::lics_vreg_t vreg_select,
  // Open-drain status pins, output enable low while the pin is pulled low.
  output logic charge_status_out_a_oe_n,
  output logic charge_status_out_b_oe_n,
  output logic input_power_good_out_oe_n,
  // Observed state.
  output lics_pkg::lics_state_t charge_state,
  output logic timer_fault
);

  localparam int FW = $clog2(FILTER_CYC + 1);

  lics_pkg::lics_cmp_t cmp;
  lics_pkg::lics_pins_t pins;
  logic tmr_en_n;
  lics_pkg::lics_state_t state;
  lics_pkg::lics_state_t next_state;
  lics_pkg::lics_state_t resume_state;
  logic [lics_pkg::LICS_TMR_W-1:0] timer;
  logic [FW-1:0] filt_count;
  logic term_filtered;
  logic src_ac;
  logic [2:0] break_count;
  logic tick;

  // All three input bundles share one synchroniser so the decodes stay coherent.
  lics_sync #(.WIDTH(lics_pkg::LICS_CMP_W + lics_pkg::LICS_PIN_W + 1)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .d({cmp_in, pins_in, safety_timer_enable_n}),
    .q({cmp, pins, tmr_en_n})
  ); // see R25

  function automatic logic is_charging(input lics_pkg::lics_state_t s);
    is_charging = (s == lics_pkg::LICS_PRECOND) || (s == lics_pkg::LICS_CONST_CUR)
      || (s == lics_pkg::LICS_CONST_VOLT) || (s == lics_pkg::LICS_BREAK);
  endfunction

  // States in which a pass path may be closed; the switch-over gap is not one of them.
  function automatic logic is_feeding(input lics_pkg::lics_state_t s);
    is_feeding = (s == lics_pkg::LICS_PRECOND) || (s == lics_pkg::LICS_CONST_CUR)
      || (s == lics_pkg::LICS_CONST_VOLT);
  endfunction

  // A disabled option gets the top count, which a stopped timer never reaches.
  function automatic logic [lics_pkg::LICS_TMR_W-1:0] timer_limit(
    input lics_pkg::lics_tmr_opt_t opt);
    case (opt)
      lics_pkg::LICS_TMR_4H: timer_limit = 15'(lics_pkg::LICS_TMR_4H_S);
      lics_pkg::LICS_TMR_6H: timer_limit = 15'(lics_pkg::LICS_TMR_6H_S);
      lics_pkg::LICS_TMR_8H: timer_limit = 15'(lics_pkg::LICS_TMR_8H_S);
      default: timer_limit = '1;
    endcase
  endfunction

  // Source choice: AC has priority whenever it is valid.
  wire logic want_ac = cmp.ac_uvlo_ok; // see R4
  wire logic any_supply = cmp.ac_uvlo_ok || cmp.usb_uvlo_ok;
  // Lockout also needs headroom over the battery, checked every cycle.
  wire logic lockout = !any_supply || !cmp.supply_above_bat; // see R1, R2, R3, R17
  wire logic pin_off = want_ac ? pins.ac_set_high_z && !pins.ac_set_floating : 1'b0; // see R8
  wire logic pin_float = want_ac ? pins.ac_set_floating : pins.usb_rate_floating; // see R8, R9
  wire logic qualified = !pin_float && cmp.battery_present; // see R7
  wire logic suspend = !cmp.battery_temp_sense_pin_in_window || cmp.die_overtemp; // see R22, R23
  wire logic timer_on = (TIMER_OPT != lics_pkg::LICS_TMR_OFF) && !tmr_en_n; // see R10, R11
  wire logic expired = timer_on && (timer >= timer_limit(TIMER_OPT));
  wire logic src_change = is_charging(state) && (want_ac != src_ac);
  wire logic timer_run = timer_on && is_charging(state); // see R26
  wire logic [FW-1:0] filt_max = FW'(FILTER_CYC);
  wire logic break_done = (break_count == 3'(lics_pkg::LICS_BREAK_CYC - 1)); // see R5

  lics_divider #(.DIV(TICK_CYC)) u_div (
    .mclk(mclk),
    .rst(rst),
    .run(timer_run),
    .tick(tick)
  ); // see R26

  always_comb
  begin
    next_state = state;
    if (lockout || pin_off)
      next_state = lics_pkg::LICS_SHUTDOWN; // see R1, R3, R8, R17
    else
    begin
      case (state)
        lics_pkg::LICS_SHUTDOWN: next_state = lics_pkg::LICS_STANDBY; // see R17
        lics_pkg::LICS_STANDBY:
          if (qualified)
            next_state = cmp.bat_below_precond ? lics_pkg::LICS_PRECOND
              : lics_pkg::LICS_CONST_CUR; // see R7, R12
        lics_pkg::LICS_PRECOND:
          if (!qualified)
            next_state = lics_pkg::LICS_STANDBY;
          else if (suspend)
            next_state = lics_pkg::LICS_TEMP_FAULT;
          else if (src_change)
            next_state = lics_pkg::LICS_BREAK;
          else if (!cmp.bat_below_precond)
            next_state = lics_pkg::LICS_CONST_CUR; // see R13
        lics_pkg::LICS_CONST_CUR:
          if (!qualified)
            next_state = lics_pkg::LICS_STANDBY;
          else if (suspend)
            next_state = lics_pkg::LICS_TEMP_FAULT;
          else if (expired)
            next_state = lics_pkg::LICS_TIMER_FAULT; // see R15
          else if (src_change)
            next_state = lics_pkg::LICS_BREAK;
          else if (cmp.bat_at_vreg)
            next_state = lics_pkg::LICS_CONST_VOLT; // see R14, R18
        lics_pkg::LICS_CONST_VOLT:
          if (!qualified)
            next_state = lics_pkg::LICS_STANDBY;
          else if (suspend)
            next_state = lics_pkg::LICS_TEMP_FAULT;
          else if (term_filtered || expired)
            next_state = lics_pkg::LICS_COMPLETE; // see R19
          else if (src_change)
            next_state = lics_pkg::LICS_BREAK;
        lics_pkg::LICS_COMPLETE:
          if (!qualified)
            next_state = lics_pkg::LICS_STANDBY;
          else if (cmp.bat_below_recharge)
            next_state = cmp.bat_below_precond ? lics_pkg::LICS_PRECOND
              : lics_pkg::LICS_CONST_CUR; // see R21
        lics_pkg::LICS_TIMER_FAULT:
          if (!qualified)
            next_state = lics_pkg::LICS_STANDBY; // see R15, R16
        lics_pkg::LICS_TEMP_FAULT:
          if (!qualified)
            next_state = lics_pkg::LICS_STANDBY;
          else if (!suspend)
            next_state = resume_state; // see R22, R23
        lics_pkg::LICS_BREAK:
          if (!qualified)
            next_state = lics_pkg::LICS_STANDBY;
          else if (break_done)
            next_state = resume_state; // see R5
        default: next_state = lics_pkg::LICS_SHUTDOWN;
      endcase
    end
  end

  wire logic entering_cc = (next_state == lics_pkg::LICS_CONST_CUR)
    && (state != lics_pkg::LICS_CONST_CUR) && (state != lics_pkg::LICS_TEMP_FAULT)
    && (state != lics_pkg::LICS_BREAK);
  wire logic path_on = is_feeding(next_state);
  // An enable of zero pulls a status pin low; a one releases it.
  wire logic next_a = !is_feeding(next_state); // see R24
  wire logic next_b = (next_state != lics_pkg::LICS_COMPLETE);
  wire logic next_pg = (next_state == lics_pkg::LICS_SHUTDOWN);
  wire lics_pkg::lics_iset_t next_iset = !path_on ? lics_pkg::LICS_ISET_NONE
    : src_ac ? lics_pkg::LICS_ISET_AC
    : pins.usb_rate_high ? lics_pkg::LICS_ISET_USB_5UL : lics_pkg::LICS_ISET_USB_1UL; // see R9

  // Both paths are judged on the next state, so they open on the edge the state leaves
  // charging and a source change never leaves the old path closed for a cycle.
  wire logic next_ac_path = path_on && src_ac && !src_change; // see R5, R23
  wire logic next_usb_path = path_on && !src_ac && !src_change; // see R5
  wire logic next_precond = (next_state == lics_pkg::LICS_PRECOND); // see R12
  wire logic next_cv = (next_state == lics_pkg::LICS_CONST_VOLT); // see R18
  wire logic next_tfault = (next_state == lics_pkg::LICS_TIMER_FAULT); // see R15
  // Source latches only while no path is closed, so paths never overlap.
  wire logic src_latch = (next_state == lics_pkg::LICS_BREAK) || !is_charging(state); // see R5
  wire logic in_break = (state == lics_pkg::LICS_BREAK);
  // A stale count from a finished cycle must never cut a fresh one short.
  wire logic timer_clear = entering_cc || (next_state == lics_pkg::LICS_SHUTDOWN)
    || (next_state == lics_pkg::LICS_STANDBY); // see R14, R17
  wire logic timer_step = tick && !expired && !suspend; // see R6, R23, R26
  wire logic filt_restart = !cmp.term_current_low || (state != lics_pkg::LICS_CONST_VOLT); // see R20

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= lics_pkg::LICS_STATE_RST; // see R25
      resume_state <= lics_pkg::LICS_STATE_RST;
      src_ac <= 1'b0;
      break_count <= '0;
    end
    else
    begin
      state <= next_state;
      if (state != lics_pkg::LICS_BREAK && state != lics_pkg::LICS_TEMP_FAULT)
        resume_state <= state;
      if (src_latch)
        src_ac <= want_ac; // see R5
      break_count <= in_break ? break_count + 3'h1 : 3'h0;
    end
  end

  // Timer freezes across suspend and keeps running through switch-over; cleared on entry to constant current and in shutdown or standby.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      timer <= '0; // see R25
    else if (timer_clear)
      timer <= '0; // see R14, R17
    else if (timer_step)
      timer <= timer + 15'h1; // see R6, R23, R26
  end

  // A held comparator must stay high for the full window; any glitch restarts it.
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      filt_count <= '0;
      term_filtered <= 1'b0;
    end
    else if (filt_restart)
    begin
      filt_count <= '0;
      term_filtered <= 1'b0;
    end
    else if (filt_count != filt_max)
      filt_count <= filt_count + FW'(1); // see R20
    else
      term_filtered <= 1'b1; // see R20
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ac_path_on <= 1'b0;
      usb_path_on <= 1'b0;
      current_setting <= lics_pkg::LICS_ISET_NONE;
      precond_current <= 1'b0;
      cv_regulate <= 1'b0;
      vreg_select <= VREG_OPT;
      charge_status_out_a_oe_n <= 1'b1;
      charge_status_out_b_oe_n <= 1'b1;
      input_power_good_out_oe_n <= 1'b1;
      charge_state <= lics_pkg::LICS_STATE_RST;
      timer_fault <= 1'b0;
    end
    else
    begin
      // Outputs follow the next state, so each changes on the same edge as charge_state.
      ac_path_on <= next_ac_path; // see R5, R23
      usb_path_on <= next_usb_path; // see R5
      current_setting <= next_iset;
      precond_current <= next_precond; // see R12
      cv_regulate <= next_cv; // see R18
      vreg_select <= VREG_OPT; // see R18
      charge_status_out_a_oe_n <= next_a; // see R24
      charge_status_out_b_oe_n <= next_b; // see R24
      input_power_good_out_oe_n <= next_pg; // see R24
      charge_state <= next_state;
      timer_fault <= next_tfault; // see R15
    end
  end

endmodule

// ### lics_sequencer_asserts.sv
`timescale 1ns/10ps
module lics_sequencer_asserts #(
  parameter lics_pkg::lics_vreg_t VREG_OPT = lics_pkg::LICS_VREG_420
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Sequencer inputs.
  input wire lics_pkg::lics_cmp_t cmp_in,
  input wire lics_pkg::lics_pins_t pins_in,
  input wire logic safety_timer_enable_n,
  // Sequencer outputs.
  input wire logic ac_path_on,
  input wire logic usb_path_on,
  input wire lics_pkg::lics_iset_t current_setting,
  input wire logic precond_current,
  input wire logic cv_regulate,
  input wire lics_pkg::lics_vreg_t vreg_select,
  input wire logic charge_status_out_a_oe_n,
  input wire logic charge_status_out_b_oe_n,
  input wire logic input_power_good_out_oe_n,
  input wire lics_pkg::lics_state_t charge_state,
  input wire logic timer_fault
);
  wire logic in_charge;

  assign in_charge = charge_state inside {lics_pkg::LICS_PRECOND, lics_pkg::LICS_CONST_CUR,
    lics_pkg::LICS_CONST_VOLT};

  default clocking dclk @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_reset_state: assert property ($fell(rst) |-> charge_state == lics_pkg::LICS_SHUTDOWN)
    else $error("not in shutdown after reset");
  a_paths_excl: assert property (!(ac_path_on && usb_path_on))
    else $error("both pass paths closed");
  a_usb_break: assert property ($rose(usb_path_on) |-> !$past(ac_path_on, 4))
    else $error("usb path closed too soon");
  a_ac_break: assert property ($rose(ac_path_on) |-> !$past(usb_path_on, 4))
    else $error("ac path closed too soon");
  a_lockout_off: assert property (!cmp_in.supply_above_bat [*4] |->
    charge_state == lics_pkg::LICS_SHUTDOWN) else $error("no shutdown in lockout");
  a_status_a: assert property ((charge_status_out_a_oe_n == 1'h0) == in_charge)
    else $error("first status pin wrong");
  a_status_b: assert property ((charge_status_out_b_oe_n == 1'h0) ==
    (charge_state == lics_pkg::LICS_COMPLETE)) else $error("second status pin wrong");
  a_power_good: assert property (input_power_good_out_oe_n ==
    (charge_state == lics_pkg::LICS_SHUTDOWN)) else $error("power good pin wrong");
  a_idle_paths: assert property (!in_charge |-> !ac_path_on && !usb_path_on)
    else $error("path closed while not charging");
  a_fault_flag: assert property (timer_fault == (charge_state == lics_pkg::LICS_TIMER_FAULT))
    else $error("timer fault flag wrong");
  a_mode_flags: assert property (precond_current == (charge_state == lics_pkg::LICS_PRECOND) &&
    cv_regulate == (charge_state == lics_pkg::LICS_CONST_VOLT)) else $error("mode flag wrong");
  a_vreg_fixed: assert property (vreg_select == VREG_OPT)
    else $error("regulation option wrong");
  a_usb_float: assert property ((pins_in.usb_rate_floating && !cmp_in.ac_uvlo_ok) [*4] |->
    !in_charge) else $error("charging with usb select floating");
  a_ac_float: assert property ((pins_in.ac_set_floating && cmp_in.ac_uvlo_ok) [*4] |->
    !in_charge) else $error("charging with ac set floating");
endmodule

bind lics_sequencer lics_sequencer_asserts #(.VREG_OPT(VREG_OPT)) i_chk (.mclk(mclk), .rst(rst),
  .cmp_in(cmp_in), .pins_in(pins_in), .safety_timer_enable_n(safety_timer_enable_n),
  .ac_path_on(ac_path_on), .usb_path_on(usb_path_on), .current_setting(current_setting),
  .precond_current(precond_current), .cv_regulate(cv_regulate), .vreg_select(vreg_select),
  .charge_status_out_a_oe_n(charge_status_out_a_oe_n),
  .charge_status_out_b_oe_n(charge_status_out_b_oe_n),
  .input_power_good_out_oe_n(input_power_good_out_oe_n), .charge_state(charge_state),
  .timer_fault(timer_fault));

// ### lics_battery_model.sv
`timescale 1ns/10ps
module lics_battery_model (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst,
  // Supply and cell conditions set by the bench.
  input wire logic ac_ok,
  input wire logic usb_ok,
  input wire logic present,
  input wire logic hold,
  input wire logic drain,
  input wire logic battery_temp_sense_pin_ok,
  input wire logic hot,
  // Pass paths from the charger.
  input wire logic ac_path_on,
  input wire logic usb_path_on,
  // Comparator results seen by the charger.
  output lics_pkg::lics_cmp_t cmp_out
);
  // Cell charge in arbitrary units; it rises only while a path is closed, so a
  // charger that leaves a path open by mistake shows up as a wrong state later.
  int level;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      level <= 0;
    else if (drain)
      level <= 100;
    else if (!hold && (ac_path_on || usb_path_on) && level < 400)
      level <= level + 1;
  end

  assign cmp_out.ac_uvlo_ok = ac_ok;
  assign cmp_out.usb_uvlo_ok = usb_ok;
  assign cmp_out.supply_above_bat = ac_ok || usb_ok;
  assign cmp_out.battery_present = present;
  assign cmp_out.bat_below_precond = level < 50;
  assign cmp_out.bat_at_vreg = level >= 200;
  assign cmp_out.bat_below_recharge = level < 150;
  assign cmp_out.term_current_low = level >= 300;
  assign cmp_out.battery_temp_sense_pin_in_window = battery_temp_sense_pin_ok;
  assign cmp_out.die_overtemp = hot;
endmodule

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
  // Short tick and filter keep the four hour timer near 29k cycles.
  localparam int TICK = 2;
  localparam int TSPAN = lics_pkg::LICS_TMR_4H_S * TICK;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic ac_ok = 1'h0;
  logic usb_ok = 1'h0;
  logic present = 1'h0;
  logic hold = 1'h0;
  logic drain = 1'h0;
  logic battery_temp_sense_pin_ok = 1'h1;
  logic hot = 1'h0;
  logic ten_n = 1'h1;
  logic hi;
  logic ac_on, usb_on, pre, cv, tf, sa, sb, pg;
  lics_pkg::lics_cmp_t cmp;
  lics_pkg::lics_pins_t pins = 4'h0;
  lics_pkg::lics_iset_t iset;
  lics_pkg::lics_vreg_t vsel;
  lics_pkg::lics_state_t st;
  int n_errors = 0;
  int checks_done = 0;
  int k1, k2;

  always #12.5 mclk = ~mclk;

  lics_battery_model i_bat (.mclk(mclk), .rst(rst), .ac_ok(ac_ok), .usb_ok(usb_ok),
    .present(present), .hold(hold), .drain(drain), .battery_temp_sense_pin_ok(battery_temp_sense_pin_ok), .hot(hot),
    .ac_path_on(ac_on), .usb_path_on(usb_on), .cmp_out(cmp));

  lics_sequencer #(.TIMER_OPT(lics_pkg::LICS_TMR_4H), .VREG_OPT(lics_pkg::LICS_VREG_435),
    .TICK_CYC(TICK), .FILTER_CYC(8)) i_dut (.mclk(mclk), .rst(rst), .cmp_in(cmp),
    .pins_in(pins), .safety_timer_enable_n(ten_n), .ac_path_on(ac_on), .usb_path_on(usb_on),
    .current_setting(iset), .precond_current(pre), .cv_regulate(cv), .vreg_select(vsel),
    .charge_status_out_a_oe_n(sa), .charge_status_out_b_oe_n(sb),
    .input_power_good_out_oe_n(pg), .charge_state(st), .timer_fault(tf));

  function automatic logic [2:0] exp_stat(input lics_pkg::lics_state_t s);
    case (s)
      lics_pkg::LICS_SHUTDOWN: return 3'h7;
      lics_pkg::LICS_PRECOND, lics_pkg::LICS_CONST_CUR, lics_pkg::LICS_CONST_VOLT: return 3'h2;
      lics_pkg::LICS_COMPLETE: return 3'h4;
      default: return 3'h6;
    endcase
  endfunction

  function automatic lics_pkg::lics_iset_t exp_iset(input logic ac, input logic rate_hi);
    if (ac)
      return lics_pkg::LICS_ISET_AC;
    return rate_hi ? lics_pkg::LICS_ISET_USB_5UL : lics_pkg::LICS_ISET_USB_1UL;
  endfunction

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  // Waits a bounded time for a state, then checks it and its status pins.
  task automatic wait_state(input lics_pkg::lics_state_t s, input int lim, output int k);
    k = 0;
    while (st !== s && k < lim)
    begin
      step(1);
      k++;
    end
    check("charge_state", 8'(st), 8'(s));
    check("status_pins", 8'({sa, sb, pg}), 8'(exp_stat(s)));
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    $display("Error watchdog expected done seen hang");
    final_report();
  end

  initial
  begin
    k1 = $urandom(32'hf01a64cc);
    step(16);
    rst = 1'h0;
    wait_state(lics_pkg::LICS_SHUTDOWN, 0, k1);
    check("timer_fault", 8'(tf), 8'h00);
    $display("test reset done");
    ac_ok = 1'h1;
    usb_ok = 1'h1;
    present = 1'h1;
    wait_state(lics_pkg::LICS_PRECOND, 20, k1);
    check("precond_current", 8'(pre), 8'h01);
    check("current_setting", 8'(iset), 8'(exp_iset(1'h1, 1'h0)));
    wait_state(lics_pkg::LICS_CONST_CUR, 200, k1);
    wait_state(lics_pkg::LICS_CONST_VOLT, 400, k1);
    check("cv_regulate", 8'(cv), 8'h01);
    check("vreg_select", 8'(vsel), 8'(lics_pkg::LICS_VREG_435));
    wait_state(lics_pkg::LICS_COMPLETE, 400, k1);
    hold = 1'h1;
    drain = 1'h1;
    step(1);
    drain = 1'h0;
    wait_state(lics_pkg::LICS_CONST_CUR, 20, k1);
    $display("test charge cycle done");
    repeat (3)
    begin
      hi = 1'($urandom);
      pins.usb_rate_high = hi;
      ac_ok = ~ac_ok;
      wait_state(lics_pkg::LICS_BREAK, 10, k1);
      wait_state(lics_pkg::LICS_CONST_CUR, 10, k1);
      check("ac_path_on", 8'(ac_on), 8'(ac_ok));
      check("usb_path_on", 8'(usb_on), 8'(!ac_ok));
      check("current_setting", 8'(iset), 8'(exp_iset(ac_ok, hi)));
    end
    $display("test source switch done");
    pins.usb_rate_floating = 1'h1;
    wait_state(lics_pkg::LICS_STANDBY, 10, k1);
    step(4);
    hi = ~hi;
    pins.usb_rate_high = hi;
    pins.usb_rate_floating = 1'h0;
    wait_state(lics_pkg::LICS_CONST_CUR, 10, k1);
    check("current_setting", 8'(iset), 8'(exp_iset(1'h0, hi)));
    ac_ok = 1'h1;
    wait_state(lics_pkg::LICS_BREAK, 10, k1);
    pins.ac_set_floating = 1'h1;
    wait_state(lics_pkg::LICS_STANDBY, 20, k1);
    step(4);
    pins.ac_set_floating = 1'h0;
    wait_state(lics_pkg::LICS_CONST_CUR, 10, k1);
    pins.ac_set_high_z = 1'h1;
    wait_state(lics_pkg::LICS_SHUTDOWN, 10, k1);
    pins.ac_set_high_z = 1'h0;
    wait_state(lics_pkg::LICS_CONST_CUR, 20, k1);
    $display("test pins done");
    hot = 1'h1;
    wait_state(lics_pkg::LICS_TEMP_FAULT, 10, k1);
    hot = 1'h0;
    wait_state(lics_pkg::LICS_CONST_CUR, 10, k1);
    battery_temp_sense_pin_ok = 1'h0;
    wait_state(lics_pkg::LICS_TEMP_FAULT, 10, k1);
    battery_temp_sense_pin_ok = 1'h1;
    wait_state(lics_pkg::LICS_CONST_CUR, 10, k1);
    $display("test thermal done");
    step(2000);
    ten_n = 1'h0;
    step(10000);
    ac_ok = 1'h0;
    wait_state(lics_pkg::LICS_BREAK, 10, k1);
    wait_state(lics_pkg::LICS_TIMER_FAULT, TSPAN, k2);
    k2 = 10000 + k1 + k2;
    check("timer_span", 8'(k2 > TSPAN - 8 && k2 < TSPAN + 24), 8'h01);
    check("timer_fault", 8'(tf), 8'h01);
    present = 1'h0;
    wait_state(lics_pkg::LICS_STANDBY, 10, k1);
    present = 1'h1;
    wait_state(lics_pkg::LICS_CONST_CUR, 10, k1);
    $display("test timer done");
    usb_ok = 1'h0;
    wait_state(lics_pkg::LICS_SHUTDOWN, 10, k1);
    step(8);
    ac_ok = 1'h1;
    wait_state(lics_pkg::LICS_CONST_CUR, 20, k1);
    $display("test power loss done");
    final_report();
  end
endmodule
